/* File: rtl/flash_seq_consts.vh */
// Constants shared by the serial flash command sequencer files
`ifndef FLASH_SEQ_CONSTS_VH
`define FLASH_SEQ_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_MODULE_CTRL 8'h00
`define OFS_FLASH_ADDR 8'h04
`define OFS_INSTR_CMD 8'h08
`define OFS_TX_DATA 8'h0C
`define OFS_TX_STATUS 8'h10
`define OFS_MODULE_STATUS 8'h14
`define OFS_RX_DATA 8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_TX_FLUSH 0
`define CTRL_RX_FLUSH 1
`define ICMD_CODE_LSB 0
`define ICMD_SIZE_LSB 8
`define ICMD_QUAD 24
`define ICMD_READ 25
`define STAT_BUSY 0
`define STAT_ACCESS 1
`define STAT_TX_NE 2
`define STAT_RX_NE 3
`define STAT_RX_CNT_LSB 16
`define TXS_COUNT_LSB 16

// ----------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------
`define RST_WORD 32'h0000_0000
`define TX_DEPTH 15
`define RX_DEPTH 16
`define ADDR_BYTES 2'h3

// ----------------------------------------------------------------
// Link timing: serial clock half period in ns and in cycles
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 25
`define SCLK_HALF_NS 100
`define SCLK_HALF_CYC ((`SCLK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: rtl/flash_buf_mem.v */
// Small dual-port word memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module flash_buf_mem #(
  parameter WIDTH = 32,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock
  input wire clk_i,
  // Write port
  input wire we_i,
  input wire [AW-1:0] waddr_i,
  input wire [WIDTH-1:0] wdata_i,
  // Read port
  input wire [AW-1:0] raddr_i,
  output reg [WIDTH-1:0] q_o
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];

  // Write-through forward so a fresh entry is never read stale
  always @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    if (we_i && (waddr_i == raddr_i)) begin
      q_o <= wdata_i;
    end else begin
      q_o <= mem[raddr_i];
    end
  end

endmodule
`default_nettype wire

/* File: rtl/flash_link.v */
// Byte shifter for the serial flash link, single or quad lane
`timescale 1ns/1ps
`default_nettype none
module flash_link #(
  parameter HALF = 4
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Byte request
  input wire start_i,
  input wire quad_i,
  input wire rx_i,
  input wire [7:0] byte_i,
  // Byte answer
  output reg done_o,
  output reg [7:0] byte_o,
  // Link pins
  output reg sclk_o,
  output reg [3:0] io_o,
  output reg [3:0] io_oe_o,
  input wire [3:0] io_i
);

  reg [3:0] meta_q;
  reg [3:0] sync_q;
  reg busy_q;
  reg quad_q;
  reg [7:0] cnt_q;
  reg [3:0] bits_q;
  reg [7:0] shift_q;
  wire [7:0] next_w;

  // Pins are resynchronised before the shifter looks at them
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= 4'h0;
      sync_q <= 4'h0;
    end else begin
      meta_q <= io_i;
      sync_q <= meta_q;
    end
  end

  // Capture happens at the falling edge, late in the high phase
  assign next_w = quad_q ? {shift_q[3:0], sync_q} : {shift_q[6:0], sync_q[1]};

  // Mode 0 shifter: data change on falling edges, flash samples on rising
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
      quad_q <= 1'b0;
      cnt_q <= 8'h00;
      bits_q <= 4'h0;
      shift_q <= 8'h00;
      done_o <= 1'b0;
      byte_o <= 8'h00;
      sclk_o <= 1'b0;
      io_o <= 4'h0;
      io_oe_o <= 4'h0;
    end else begin
      done_o <= 1'b0;
      if (!busy_q) begin
        sclk_o <= 1'b0;
        if (start_i) begin
          busy_q <= 1'b1;
          quad_q <= quad_i;
          shift_q <= byte_i;
          cnt_q <= HALF[7:0] - 8'h01;
          bits_q <= quad_i ? 4'h2 : 4'h8;
          io_o <= quad_i ? byte_i[7:4] : {3'h0, byte_i[7]};
          io_oe_o <= quad_i ? (rx_i ? 4'h0 : 4'hF) : 4'h1;
        end
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end else begin
        cnt_q <= HALF[7:0] - 8'h01;
        sclk_o <= ~sclk_o;
        if (sclk_o) begin
          shift_q <= next_w;
          bits_q <= bits_q - 4'h1;
          io_o <= quad_q ? next_w[7:4] : {3'h0, next_w[7]};
          if (bits_q == 4'h1) begin
            busy_q <= 1'b0;
            done_o <= 1'b1;
            byte_o <= next_w;
          end
        end
      end
    end
  end

endmodule
`default_nettype wire

/* File: rtl/flash_seq.v */
// Register-driven command sequencer for an external serial flash
//
// The address-and-strobe port and the address map were decided locally.
`include "flash_seq_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module flash_seq #(
  parameter HALF = `SCLK_HALF_CYC,
  parameter RXD = `RX_DEPTH
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Register port
  input wire [7:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  // Flash link pins
  output reg cs_n_o,
  output wire sclk_o,
  output wire [3:0] io_o,
  output wire [3:0] io_oe_o,
  input wire [3:0] io_i
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam ST_IDLE = 5'b00001;
  localparam ST_CMD = 5'b00010;
  localparam ST_ADDR = 5'b00100;
  localparam ST_DATA = 5'b01000;
  localparam ST_END = 5'b10000;
  localparam TXD = `TX_DEPTH;

  reg [4:0] state_q;
  reg active_q;
  reg [31:0] addr_q;
  reg [7:0] code_q;
  reg [15:0] size_q;
  reg quad_q;
  reg read_q;
  reg [15:0] tx_words_q;
  reg [3:0] tx_wp_q;
  reg [3:0] tx_rp_q;
  reg [3:0] tx_cnt_q;
  reg [3:0] rx_wp_q;
  reg [3:0] rx_rp_q;
  reg [4:0] rx_cnt_q;
  reg [1:0] idx_q;
  reg [15:0] left_q;
  reg [31:0] word_q;
  reg [1:0] wbyte_q;
  reg [31:0] rxw_q;
  reg pend_q;
  reg lstart_q;
  reg lquad_q;
  reg lrx_q;
  reg [7:0] lbyte_q;

  wire ldone;
  wire [7:0] lrx_byte;
  wire [31:0] tx_q;
  wire [31:0] rx_q;
  wire sel_ctrl = (addr_i == `OFS_MODULE_CTRL);
  wire sel_cmd = (addr_i == `OFS_INSTR_CMD);
  wire tx_flush = wr_i && sel_ctrl && wdata_i[`CTRL_TX_FLUSH];
  wire rx_flush = wr_i && sel_ctrl && wdata_i[`CTRL_RX_FLUSH];
  wire tx_full = (tx_cnt_q == TXD[3:0]);
  wire tx_push = wr_i && (addr_i == `OFS_TX_DATA) && !tx_full;
  wire rx_pop = rd_i && (addr_i == `OFS_RX_DATA) && (rx_cnt_q != 5'h00);
  wire start_cmd = wr_i && sel_cmd && !active_q;
  wire fetch = state_q[3] && !read_q && !pend_q && (wbyte_q == 2'h0) &&
    (tx_cnt_q != 4'h0) && (left_q != 16'h0000);
  wire [31:0] send_word = (wbyte_q == 2'h0) ? tx_q : word_q;
  wire last_byte = (left_q == 16'h0001);
  wire rx_word_end = ldone && state_q[3] && read_q &&
    ((wbyte_q == 2'h3) || last_byte);
  wire rx_push = rx_word_end && (rx_cnt_q != RXD[4:0]);
  wire [31:0] rx_word = {rxw_q[23:0], lrx_byte};

  // ----------------------------------------------------------------
  // Buffers
  // ----------------------------------------------------------------
  reg [3:0] tx_rp_d;
  reg [3:0] rx_rp_d;

  // Next read pointers feed the memories so read data track the head
  always @* begin
    tx_rp_d = tx_rp_q;
    rx_rp_d = rx_rp_q;
    if (tx_flush) begin
      tx_rp_d = 4'h0;
    end else if (fetch) begin
      tx_rp_d = (tx_rp_q == TXD[3:0] - 4'h1) ? 4'h0 : tx_rp_q + 4'h1;
    end
    if (rx_flush) begin
      rx_rp_d = 4'h0;
    end else if (rx_pop) begin
      rx_rp_d = rx_rp_q + 4'h1;
    end
  end

  flash_buf_mem #(
    .WIDTH(32),
    .DEPTH(TXD),
    .AW(4)
  ) u_tx_mem (
    .clk_i(clk_i),
    .we_i(tx_push),
    .waddr_i(tx_wp_q),
    .wdata_i(wdata_i),
    .raddr_i(tx_rp_d),
    .q_o(tx_q)
  );

  flash_buf_mem #(
    .WIDTH(32),
    .DEPTH(RXD),
    .AW(4)
  ) u_rx_mem (
    .clk_i(clk_i),
    .we_i(rx_push),
    .waddr_i(rx_wp_q),
    .wdata_i(rx_word),
    .raddr_i(rx_rp_d),
    .q_o(rx_q)
  );

  // Transmit pointers and counters; a flush beats a same-cycle push or pop
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_wp_q <= 4'h0;
      tx_rp_q <= 4'h0;
      tx_cnt_q <= 4'h0;
      tx_words_q <= 16'h0000;
    end else begin
      tx_rp_q <= tx_rp_d;
      if (tx_flush) begin
        tx_wp_q <= 4'h0;
        tx_cnt_q <= 4'h0;
        tx_words_q <= 16'h0000;
      end else begin
        if (tx_push) begin
          tx_wp_q <= (tx_wp_q == TXD[3:0] - 4'h1) ? 4'h0 : tx_wp_q + 4'h1;
          tx_words_q <= tx_words_q + 16'h0001;
        end
        if (tx_push && !fetch) begin
          tx_cnt_q <= tx_cnt_q + 4'h1;
        end else if (fetch && !tx_push) begin
          tx_cnt_q <= tx_cnt_q - 4'h1;
        end
      end
    end
  end

  // Receive pointers; a full receive buffer drops further words
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_wp_q <= 4'h0;
      rx_rp_q <= 4'h0;
      rx_cnt_q <= 5'h00;
    end else begin
      rx_rp_q <= rx_rp_d;
      if (rx_flush) begin
        rx_wp_q <= 4'h0;
        rx_cnt_q <= 5'h00;
      end else begin
        if (rx_push) begin
          rx_wp_q <= rx_wp_q + 4'h1;
        end
        if (rx_push && !rx_pop) begin
          rx_cnt_q <= rx_cnt_q + 5'h01;
        end else if (rx_pop && !rx_push) begin
          rx_cnt_q <= rx_cnt_q - 5'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Address and command registers
  // ----------------------------------------------------------------
  // Command fields are frozen while an access runs
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      addr_q <= `RST_WORD;
      code_q <= 8'h00;
      size_q <= 16'h0000;
      quad_q <= 1'b0;
      read_q <= 1'b0;
    end else begin
      if (wr_i && (addr_i == `OFS_FLASH_ADDR)) begin
        addr_q <= wdata_i;
      end
      if (start_cmd) begin
        code_q <= wdata_i[`ICMD_CODE_LSB +: 8];
        size_q <= wdata_i[`ICMD_SIZE_LSB +: 16];
        quad_q <= wdata_i[`ICMD_QUAD];
        read_q <= wdata_i[`ICMD_READ];
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // A program stalls with the select held low while the buffer is dry
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      active_q <= 1'b0;
      cs_n_o <= 1'b1;
      idx_q <= 2'h0;
      left_q <= 16'h0000;
      word_q <= `RST_WORD;
      wbyte_q <= 2'h0;
      rxw_q <= `RST_WORD;
      pend_q <= 1'b0;
      lstart_q <= 1'b0;
      lquad_q <= 1'b0;
      lrx_q <= 1'b0;
      lbyte_q <= 8'h00;
    end else begin
      lstart_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (start_cmd) begin
            active_q <= 1'b1;
            cs_n_o <= 1'b0;
            lstart_q <= 1'b1;
            lquad_q <= 1'b0;
            lrx_q <= 1'b0;
            lbyte_q <= wdata_i[`ICMD_CODE_LSB +: 8];
            left_q <= wdata_i[`ICMD_SIZE_LSB +: 16];
            wbyte_q <= 2'h0;
            rxw_q <= `RST_WORD;
            state_q <= ST_CMD;
          end
        end
        ST_CMD: begin
          if (ldone) begin
            lstart_q <= 1'b1;
            lquad_q <= quad_q;
            lbyte_q <= addr_q[23:16];
            idx_q <= `ADDR_BYTES - 2'h1;
            state_q <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          if (ldone) begin
            if (idx_q != 2'h0) begin
              lstart_q <= 1'b1;
              lbyte_q <= (idx_q == 2'h2) ? addr_q[15:8] : addr_q[7:0];
              idx_q <= idx_q - 2'h1;
            end else if (left_q == 16'h0000) begin
              state_q <= ST_END;
            end else begin
              lrx_q <= read_q;
              pend_q <= 1'b0;
              state_q <= ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (!pend_q) begin
            if (read_q) begin
              lstart_q <= 1'b1;
              lbyte_q <= 8'h00;
              pend_q <= 1'b1;
            end else if ((wbyte_q != 2'h0) || fetch) begin
              lstart_q <= 1'b1;
              lbyte_q <= send_word[31:24];
              word_q <= {send_word[23:0], 8'h00};
              pend_q <= 1'b1;
            end
          end else if (ldone) begin
            pend_q <= 1'b0;
            left_q <= left_q - 16'h0001;
            wbyte_q <= wbyte_q + 2'h1;
            rxw_q <= rx_word_end ? `RST_WORD : rx_word;
            if (last_byte) begin
              state_q <= ST_END;
            end
          end
        end
        ST_END: begin
          cs_n_o <= 1'b1;
          active_q <= 1'b0;
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
          active_q <= 1'b0;
          cs_n_o <= 1'b1;
        end
      endcase
    end
  end

  flash_link #(
    .HALF(HALF)
  ) u_link (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(lstart_q),
    .quad_i(lquad_q),
    .rx_i(lrx_q),
    .byte_i(lbyte_q),
    .done_o(ldone),
    .byte_o(lrx_byte),
    .sclk_o(sclk_o),
    .io_o(io_o),
    .io_oe_o(io_oe_o),
    .io_i(io_i)
  );

  // ----------------------------------------------------------------
  // Read back
  // ----------------------------------------------------------------
  // Read data stand only in the cycle after the strobe
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= `RST_WORD;
    end else if (rd_i) begin
      case (addr_i)
        `OFS_FLASH_ADDR: rdata_o <= addr_q;
        `OFS_INSTR_CMD: rdata_o <= {6'h00, read_q, quad_q, size_q, code_q};
        `OFS_TX_STATUS: rdata_o <= {tx_words_q, 12'h000, tx_cnt_q};
        `OFS_MODULE_STATUS: rdata_o <= {11'h000, rx_cnt_q, 12'h000,
          (rx_cnt_q != 5'h00), (tx_cnt_q != 4'h0), active_q,
          active_q};
        `OFS_RX_DATA: rdata_o <= rx_pop ? rx_q : `RST_WORD;
        default: rdata_o <= `RST_WORD;
      endcase
    end else begin
      rdata_o <= `RST_WORD;
    end
  end

endmodule
`default_nettype wire

/* File: rtl/flash_seq_tie.v */
// Empty unit: the sequencer needs no tie-off logic of its own
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* File: verification/flash_seq_asserts.sv */
// Port checker for the flash command sequencer
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_consts.vh"
module flash_seq_asserts #(
  parameter HALF = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  // Link pins
  input wire logic cs_n_o,
  input wire logic sclk_o,
  input wire logic [3:0] io_o,
  input wire logic [3:0] io_oe_o,
  input wire logic [3:0] io_i
);
  logic [7:0] hi_q;
  logic stat_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Length of the high phase and status reads taken mid-frame
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hi_q <= 8'h00;
      stat_q <= 1'b0;
    end else begin
      hi_q <= sclk_o ? hi_q + 8'h01 : 8'h00;
      stat_q <= rd_i && addr_i == `OFS_MODULE_STATUS && !cs_n_o;
    end
  end
  chk_rdata_quiet: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data not zero outside read slot");
  chk_start_frame: assert property (
    wr_i && addr_i == `OFS_INSTR_CMD && cs_n_o && $past(cs_n_o) |=> !cs_n_o)
    else $error("command write did not open a frame");
  chk_sclk_idle: assert property (cs_n_o |-> !sclk_o)
    else $error("serial clock moved outside a frame");
  chk_busy_frame: assert property (stat_q |-> rdata_o[`STAT_BUSY])
    else $error("busy low during a frame");
  chk_access_frame: assert property (stat_q |-> rdata_o[`STAT_ACCESS])
    else $error("access bit low during a frame");
  // Select high means the frame is over, so both status bits must be low
  chk_access_clear: assert property (
    rd_i && addr_i == `OFS_MODULE_STATUS && cs_n_o |=>
    !rdata_o[`STAT_ACCESS] && !rdata_o[`STAT_BUSY])
    else $error("access bit still set after the frame");
  chk_data_steady: assert property (
    sclk_o |-> $stable(io_o) && $stable(io_oe_o))
    else $error("lanes changed while serial clock high");
  chk_high_len: assert property ($fell(sclk_o) |-> hi_q == 8'(HALF))
    else $error("serial clock high phase has wrong length");
  chk_reset_idle: assert property (
    $fell(rst_i) |-> cs_n_o && !sclk_o && io_oe_o == 4'h0)
    else $error("link not idle after reset");
endmodule
bind flash_seq flash_seq_asserts #(.HALF(HALF)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cs_n_o(cs_n_o),
  .sclk_o(sclk_o), .io_o(io_o), .io_oe_o(io_oe_o), .io_i(io_i)
);
`default_nettype wire

/* File: verification/flash_model.sv */
// Behavioural serial flash on the far side of the link
`timescale 1ns/1ps
`default_nettype none
module flash_model (
  // Link pins seen from the flash
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic [3:0] io_i,
  output logic [3:0] io_o
);
  logic [7:0] log_q[$];
  logic [7:0] sh_q;
  int cap_n;
  int out_n;
  logic bit_w;
  logic last_q;
  // Answer byte n of a frame is 30h plus n, MSB first
  function automatic logic pat_bit(input int n);
    logic [7:0] b;
    b = 8'h30 + 8'(n / 8);
    return b[7 - n % 8];
  endfunction
  // A new frame restarts both bit counters
  always @(negedge cs_n_i) begin
    cap_n = 0;
    out_n = 0;
  end
  // Host lane sampled on the rising edge, logged per byte
  always @(posedge sclk_i) begin
    sh_q = {sh_q[6:0], io_i[0]};
    cap_n = cap_n + 1;
    if (cap_n % 8 == 0) begin
      log_q.push_back(sh_q);
    end
  end
  // Next answer bit follows each falling edge
  always @(negedge sclk_i) begin
    if (!cs_n_i) begin
      out_n = out_n + 1;
    end
  end
  assign bit_w = pat_bit(out_n);
  // Released lines show the inverse, so stale data cannot pass
  always @(bit_w or cs_n_i) begin
    if (!cs_n_i) begin
      last_q = bit_w;
    end
  end
  assign io_o = cs_n_i ? {4{~last_q}} : {4{bit_w}};
endmodule
`default_nettype wire

/* File: verification/tb_flash_seq.sv */
// Self-checking bench for the flash command sequencer
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_consts.vh"
module tb_flash_seq;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  wire [31:0] rdata_o;
  wire cs_n_o;
  wire sclk_o;
  wire [3:0] io_o;
  wire [3:0] io_oe_o;
  wire [3:0] mdl_io;
  wire [3:0] lane_w;
  int fail_count = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [31:0] v;
  logic [7:0] exp8 [8] = '{8'h02, 8'h12, 8'h34, 8'h56,
                           8'hA1, 8'hB2, 8'hC3, 8'hD4};
  // 40 MHz system clock
  always #12.5 clk_i = ~clk_i;
  // Each lane carries whichever party enables it
  assign lane_w = (io_oe_o & io_o) | (~io_oe_o & mdl_io);
  flash_seq #(.HALF(4), .RXD(16)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cs_n_o(cs_n_o),
    .sclk_o(sclk_o), .io_o(io_o), .io_oe_o(io_oe_o), .io_i(lane_w)
  );
  flash_model u_mdl (
    .cs_n_i(cs_n_o), .sclk_i(sclk_o), .io_i(lane_w), .io_o(mdl_io)
  );
  task automatic chk(input string nm, input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic rc(input string nm, input logic [7:0] a,
                    input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(nm, d, exp);
  endtask
  // Poll busy under a bound; a hang shows up as a mismatch
  task automatic wait_idle;
    int n;
    n = 0;
    v = 32'h1;
    while (v[`STAT_BUSY] !== 1'b0 && n < 3000) begin
      rd(`OFS_MODULE_STATUS, v);
      n++;
    end
    chk("idle", {31'h0, v[`STAT_BUSY]}, 32'h0);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Cycle ceiling well above the few thousand cycles needed
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      end_of_test();
    end
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rc("status", `OFS_MODULE_STATUS, 32'h0);
    rc("txstat", `OFS_TX_STATUS, 32'h0);
    rc("unmapped", 8'h1C, 32'h0);
    $display("test reset done");
    wr(`OFS_TX_DATA, 32'h1111_1111);
    wr(`OFS_TX_DATA, 32'h2222_2222);
    rc("tx_not_empty_flag", `OFS_MODULE_STATUS, 32'h4);
    rc("txcount", `OFS_TX_STATUS, 32'h0002_0002);
    wr(`OFS_MODULE_CTRL, 32'h1);
    rc("txflush", `OFS_TX_STATUS, 32'h0);
    rc("txempty", `OFS_MODULE_STATUS, 32'h0);
    for (int i = 0; i < 16; i++) begin
      wr(`OFS_TX_DATA, 32'(i));
    end
    rc("txfull", `OFS_TX_STATUS, 32'h000F_000F);
    wr(`OFS_MODULE_CTRL, 32'h1);
    $display("test tx buffer done");
    u_mdl.log_q.delete();
    wr(`OFS_FLASH_ADDR, 32'h0012_3456);
    // Sector erase: zero byte count sends only code and address
    wr(`OFS_INSTR_CMD, 32'h0000_0020);
    wait_idle();
    chk("erasebytes", 32'(u_mdl.log_q.size()), 32'd4);
    chk("erasecode", {24'h0, u_mdl.log_q[0]}, 32'h20);
    u_mdl.log_q.delete();
    wr(`OFS_TX_DATA, 32'hA1B2_C3D4);
    wr(`OFS_INSTR_CMD, 32'h0000_0402);
    rd(`OFS_MODULE_STATUS, v);
    chk("busy", {30'h0, v[1:0]}, 32'h3);
    wr(`OFS_INSTR_CMD, 32'h0000_0103);
    wait_idle();
    rc("cmdkeep", `OFS_INSTR_CMD, 32'h0000_0402);
    rc("txdrain", `OFS_TX_STATUS, 32'h0001_0000);
    rc("released", `OFS_MODULE_STATUS, 32'h0);
    chk("nbytes", 32'(u_mdl.log_q.size()), 32'd8);
    for (int i = 0; i < 8 && i < u_mdl.log_q.size(); i++) begin
      chk("mosi", {24'h0, u_mdl.log_q[i]}, {24'h0, exp8[i]});
    end
    $display("test program done");
    wr(`OFS_MODULE_CTRL, 32'h2);
    wr(`OFS_INSTR_CMD, 32'h0200_0503);
    wait_idle();
    rc("rxstat", `OFS_MODULE_STATUS, 32'h0002_0008);
    rc("rx0", `OFS_RX_DATA, 32'h3435_3637);
    rc("rx1", `OFS_RX_DATA, 32'h0000_0038);
    rc("rxnone", `OFS_RX_DATA, 32'h0);
    // Status-style read code: handled as a plain four-byte read after code and address
    wr(`OFS_INSTR_CMD, 32'h0200_0405);
    wait_idle();
    rc("rxone", `OFS_MODULE_STATUS, 32'h0001_0008);
    wr(`OFS_MODULE_CTRL, 32'h2);
    rc("rxflush", `OFS_MODULE_STATUS, 32'h0);
    // Quad read of 3 bytes: 14 falls of code and address come first,
    // so the lanes carry frame bits 14 to 19 of the answer pattern
    wr(`OFS_INSTR_CMD, 32'h0300_036B);
    wait_idle();
    rc("rxquad", `OFS_RX_DATA, 32'h000F_00FF);
    $display("test read done");
    end_of_test();
  end
endmodule
`default_nettype wire
